// *** pkg/asp_pkg.sv ***
package asp_pkg;
	// ------------------------------------------------------------
	// register map and bus widths
	// ------------------------------------------------------------
	localparam int          ADDR_W   = 3;     // register index width
	localparam logic [2:0]  A_DATA   = 3'h0;  // serial_data_buf
	localparam logic [2:0]  A_CTRL1  = 3'h1;  // serial_ctrl_one
	localparam logic [2:0]  A_CTRL2  = 3'h2;  // serial_ctrl_two
	localparam logic [2:0]  A_STATUS = 3'h3;  // serial_status
	localparam logic [2:0]  A_BAUD   = 3'h4;  // sample-rate divisor
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int C1_R8   = 7;               // rx_ninth_bit, read only
	localparam int C1_T8   = 6;               // tx_ninth_bit
	localparam int C1_M    = 4;               // 9-bit characters
	localparam int C1_WAKE = 3;               // 1 = address mark wakeup
	localparam int C2_TIE  = 7;               // tx_empty_irq_en
	localparam int C2_TX_DONE_IRQ_EN = 6;               // tx_done_irq_en
	localparam int C2_RIE  = 5;               // receive irq enable
	localparam int C2_ILIE = 4;               // idle irq enable
	localparam int C2_TE   = 3;               // tx_enable
	localparam int C2_RE   = 2;               // receive enable
	localparam int C2_RWU  = 1;               // rx_standby
	localparam int C2_SBK  = 0;               // send_break
	localparam int S_TX_BUF_EMPTY  = 7;               // tx_buf_empty
	localparam int S_TC    = 6;               // tx_done_flag
	localparam int S_RX_BUF_FULL  = 5;               // rx_buf_full
	localparam int S_IDLE  = 4;               // receiver idle
	localparam int S_OVR   = 3;               // receiver overrun
	localparam int S_NF    = 2;               // rx_noise_flag
	localparam int S_FE    = 1;               // frame_err_flag
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL2_RST = 8'h00; // all enables off
	localparam logic [7:0] BAUD_RST  = 8'h00; // fastest sample rate
	localparam logic       TX_BUF_EMPTY_RST  = 1'b1;  // buffer empty
	localparam logic       TC_RST    = 1'b1;  // nothing in progress
	// ------------------------------------------------------------
	// cycle and bit counts
	// ------------------------------------------------------------
	localparam logic [3:0] SMP_LAST = 4'hF;   // 16 samples per bit
	localparam logic [3:0] SMP_A    = 4'h7;   // first vote sample
	localparam logic [3:0] SMP_B    = 4'h8;   // second vote sample
	localparam logic [3:0] SMP_C    = 4'h9;   // third vote sample
	localparam logic [3:0] LEN8     = 4'hA;   // 8-bit frame length
	localparam logic [3:0] LEN9     = 4'hB;   // 9-bit frame length
	localparam logic [7:0] IDLE8    = 8'hA0;  // 10 ones in samples
	localparam logic [7:0] IDLE9    = 8'hB0;  // 11 ones in samples
endpackage

// *** verilog/asp_core.sv ***
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
// Functional notes
// R1: M bit selects 8 or 9 bits
// R2: both directions share one baud generator
// R3: enable plus write sends preamble, then data
// R4: frame has zero start, one stop
// R5: empty flag sets on buffer-to-shifter transfer
// R6: idle pin high; released when disabled idle
// R7: send-break repeats all-zero characters
// R8: after break, drive at least one one
// R9: idle character all ones; preamble starts transmissions
// R10: disable waits for last character; re-enable queues preamble
// R11: empty flag requests interrupt when enabled
// R12: done flag means fully idle; interrupts
// R13: received character goes to buffer, full flag
// R14: standby suppresses receiver interrupts
// R15: idle-line wakeup after 10/11 ones
// R16: address-mark wakeup on msb one; selectable
// R17: sixteen samples; disagreement sets noise with full
// R18: bad stop sets framing flag with full
// R19: overrun when buffer unread at next character
// R20: idle flag after 10/11 ones
// R21: received ninth bit loads with buffer; no reset
// R22: transmit ninth bit loads with shifter; no reset
// R23: empty flag clears by status read, data write
// R24: receive flags clear by status read, data read
// R25: overrun with framing error sets only overrun
// R26: transmit interrupt enable gates empty requests
// R27: sampling runs at sixteen times baud
module asp_core
	import asp_pkg::*;
(
	input  wire logic                      clock,    // 200 MHz system clock
	input  wire logic                      rst,      // async reset, active high
	input  wire logic                      clk_en,   // freezes all state when low
	input  wire logic [asp_pkg::ADDR_W-1:0] addr,     // register index
	input  wire logic [7:0]                wr_data,  // write data
	input  wire logic                      wr_stb,   // write strobe
	input  wire logic                      rd_stb,   // read strobe
	output logic      [7:0]                rd_data,  // read data, next cycle
	input  wire logic                      rx_pin,   // serial input
	output logic                           tx_pin,   // serial output level
	output logic                           tx_oe_n,  // low while driving tx_pin
	output logic                           irq       // interrupt request
);
	import asp_pkg::*;

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0] ctrl2;        // enables, standby, break
	logic [7:0] baud_div;     // sample divisor
	logic       m_nine;       // 9-bit characters
	logic       wake_am;      // wakeup method
	logic       tx_ninth;     // tx_ninth_bit
	logic       rx_ninth;     // rx_ninth_bit
	logic [7:0] tx_buf;       // transmit side of data buffer
	logic [7:0] rx_buf;       // receive side of data buffer
	logic       tx_buf_empty;         // tx_buf_empty
	logic       tc;           // tx_done_flag
	logic       rx_buf_full;         // rx_buf_full
	logic       idle_f;       // receiver idle flag
	logic       ovr;          // overrun flag
	logic       nf;           // rx_noise_flag
	logic       fe;           // frame_err_flag
	logic       tx_buf_empty_arm;     // status seen with empty set
	logic       tc_arm;       // status seen with done set
	logic       rx_arm;       // status seen with rx flag set
	logic [7:0] baud_cnt;     // baud down counter
	logic [3:0] tx_ph;        // sample phase in tx bit
	logic [9:0] tx_sh;        // bits queued behind pin
	logic [3:0] tx_left;      // bits left in shifter
	logic       tx_busy;      // a character is on the line
	logic       pre_pend;     // preamble queued
	logic       brk_end;      // trailing one owed after break
	logic       rx_s1;        // sync stage one
	logic       rx_s2;        // sync stage two
	logic [3:0] rx_ph;        // sample phase in rx bit
	logic [3:0] rx_bit;       // rx bit index, 0 = start
	logic [8:0] rx_data;      // assembled data bits
	logic       smp_a;        // vote sample a
	logic       smp_b;        // vote sample b
	logic       noise;        // noise seen in this character
	logic [7:0] idle_cnt;     // high-line sample count
	logic       idle_armed;   // idle flag may fire

	typedef enum logic {RX_IDLE, RX_BUSY} asp_rx_state_t;
	asp_rx_state_t rx_st;     // receiver state

	// ------------------------------------------------------------
	// decode and derived terms
	// ------------------------------------------------------------
	wire te   = ctrl2[C2_TE];                      // transmit enable
	wire re   = ctrl2[C2_RE];                      // receive enable
	wire rx_standby  = ctrl2[C2_RWU];                     // standby
	wire send_break  = ctrl2[C2_SBK];                     // send break
	wire wr_c = clk_en & wr_stb;                   // write taken
	wire rd_c = clk_en & rd_stb;                   // read taken
	wire st_rd = rd_c & (addr == A_STATUS);        // status read
	wire dt_rd = rd_c & (addr == A_DATA);          // data read
	wire dt_wr = wr_c & (addr == A_DATA);          // data write
	wire c2_wr = wr_c & (addr == A_CTRL2);         // control two write
	wire te_rise = c2_wr & wr_data[C2_TE] & ~te;   // enable set from zero
	wire [3:0] flen = m_nine ? LEN9 : LEN8;        // frame length [R1]
	wire [7:0] ithr = m_nine ? IDLE9 : IDLE8;      // idle length [R15]
	wire smp_tick = clk_en & (baud_cnt == 8'h00);  // 16x sample tick
	wire tx_tick = smp_tick & (tx_ph == SMP_LAST); // tx bit boundary
	wire tx_free = (tx_left == 4'h0);              // shifter drained
	wire sel_brk = send_break & te;                       // break requested
	wire load_brk = tx_tick & tx_free & sel_brk;
	wire load_one = tx_tick & tx_free & ~sel_brk & brk_end;
	wire load_pre = tx_tick & tx_free & ~sel_brk & ~brk_end & pre_pend;
	wire load_dat = tx_tick & tx_free & ~sel_brk & ~brk_end & ~pre_pend & ~tx_buf_empty;
	wire go_idle = tx_tick & tx_free & ~sel_brk & ~brk_end & ~pre_pend & tx_buf_empty;
	wire maj = (smp_a & smp_b) | (smp_a & rx_s2) | (smp_b & rx_s2);   // vote
	wire dis = ~((smp_a == smp_b) & (smp_b == rx_s2));               // conflict
	wire rx_eval = smp_tick & (rx_st == RX_BUSY) & (rx_ph == SMP_C);
	wire rx_done = rx_eval & (rx_bit == flen - 4'h1);
	wire rx_msb = m_nine ? rx_data[8] : rx_data[7];
	wire am_wake = rx_done & re & rx_standby & wake_am & rx_msb;   // [R16]
	wire accept = rx_done & re & (~rx_standby | am_wake);          // [R14]
	wire rx_clr = dt_rd & rx_arm;                           // [R24]
	wire idle_hit = smp_tick & (rx_st == RX_IDLE) & rx_s2 & (idle_cnt == ithr - 8'h01);
	wire il_wake = idle_hit & re & rx_standby & ~wake_am;          // [R15]

	// ------------------------------------------------------------
	// shared baud and sample generator
	// ------------------------------------------------------------
	// one divider feeds both directions at sixteen samples per bit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			baud_cnt <= 8'h00;
		end else if (clk_en) begin
			if (baud_cnt == 8'h00) begin
				baud_cnt <= baud_div;  // reload [R2] [R27]
			end else begin
				baud_cnt <= baud_cnt - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// control two; wakeup clears standby unless software writes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl2    <= CTRL2_RST;
			baud_div <= BAUD_RST;
		end else begin
			if (c2_wr) begin
				ctrl2 <= wr_data;
			end else if (am_wake | il_wake) begin
				ctrl2[C2_RWU] <= 1'b0;  // leave standby [R15] [R16]
			end
			if (wr_c & (addr == A_BAUD)) begin
				baud_div <= wr_data;
			end
		end
	end

	// control one and buffers keep their value through reset
	always_ff @(posedge clock) begin
		if (wr_c & (addr == A_CTRL1)) begin
			tx_ninth <= wr_data[C1_T8];
			m_nine   <= wr_data[C1_M];   // [R1]
			wake_am  <= wr_data[C1_WAKE]; // method select [R16]
		end
		if (dt_wr) begin
			tx_buf <= wr_data;
		end
		if (accept & ~rx_buf_full) begin
			rx_buf   <= rx_data[7:0];    // [R13]
			rx_ninth <= rx_data[8];      // same transfer [R21]
		end
	end

	// ------------------------------------------------------------
	// read port and interrupt request
	// ------------------------------------------------------------
	// read data for one cycle only, zero otherwise and when unmapped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (clk_en) begin
			rd_data <= 8'h00;
			if (rd_stb) begin
				if (addr == A_DATA) begin
					rd_data <= rx_buf;
				end else if (addr == A_CTRL1) begin
					rd_data <= {rx_ninth, tx_ninth, 1'b0, m_nine, wake_am, 3'h0};
				end else if (addr == A_CTRL2) begin
					rd_data <= ctrl2;
				end else if (addr == A_STATUS) begin
					rd_data <= {tx_buf_empty, tc, rx_buf_full, idle_f, ovr, nf, fe, 1'b0};
				end else if (addr == A_BAUD) begin
					rd_data <= baud_div;
				end
			end
		end
	end

	// gated request; receiver terms quiet in standby or disabled
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= (ctrl2[C2_TIE] & tx_buf_empty)            // [R11] [R26]
			     | (ctrl2[C2_TX_DONE_IRQ_EN] & tc)             // [R12]
			     | (re & ~rx_standby & ((ctrl2[C2_RIE] & (rx_buf_full | ovr))
			     | (ctrl2[C2_ILIE] & idle_f)));       // [R14] [R20]
		end
	end

	// ------------------------------------------------------------
	// transmit flags
	// ------------------------------------------------------------
	// set wins over the read-then-write clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_buf_empty     <= TX_BUF_EMPTY_RST;
			tc       <= TC_RST;
			tx_buf_empty_arm <= 1'b0;
			tc_arm   <= 1'b0;
		end else begin
			if (st_rd & tx_buf_empty) begin
				tx_buf_empty_arm <= 1'b1;
			end else if (dt_wr) begin
				tx_buf_empty_arm <= 1'b0;
			end
			if (st_rd & tc) begin
				tc_arm <= 1'b1;
			end else if (dt_wr) begin
				tc_arm <= 1'b0;
			end
			if (load_dat) begin
				tx_buf_empty <= 1'b1;                    // [R5]
			end else if (dt_wr & tx_buf_empty_arm) begin
				tx_buf_empty <= 1'b0;                    // [R23]
			end
			if (clk_en & tx_buf_empty & ~tx_busy & ~pre_pend & ~brk_end & ~sel_brk) begin
				tc <= 1'b1;                      // fully idle [R12]
			end else if (dt_wr & tc_arm) begin
				tc <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// transmit shifter
	// ------------------------------------------------------------
	// picks the next character at each free bit boundary
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_ph    <= 4'h0;
			tx_sh    <= 10'h3FF;
			tx_left  <= 4'h0;
			tx_busy  <= 1'b0;
			tx_pin   <= 1'b1;
			tx_oe_n  <= 1'b1;
			pre_pend <= 1'b0;
			brk_end  <= 1'b0;
		end else if (clk_en) begin
			tx_oe_n <= ~(te | tx_busy | ~tx_buf_empty | pre_pend | brk_end);  // [R6] [R10]
			if (smp_tick) begin
				tx_ph <= tx_ph + 4'h1;
			end
			if (te_rise) begin
				pre_pend <= 1'b1;                // extra preamble [R10]
			end else if (load_pre) begin
				pre_pend <= 1'b0;
			end
			if (load_brk) begin
				tx_pin  <= 1'b0;                 // all zeros, no framing [R7]
				tx_sh   <= 10'h000;
				tx_left <= flen - 4'h1;
				tx_busy <= 1'b1;
				brk_end <= 1'b1;
			end else if (load_one) begin
				tx_pin  <= 1'b1;                 // one trailing one [R8]
				tx_busy <= 1'b1;
				brk_end <= 1'b0;
			end else if (load_pre) begin
				tx_pin  <= 1'b1;                 // idle character [R3] [R9]
				tx_sh   <= 10'h3FF;
				tx_left <= flen - 4'h1;
				tx_busy <= 1'b1;
			end else if (load_dat) begin
				tx_pin  <= 1'b0;                 // start bit [R4]
				tx_sh   <= m_nine ? {1'b1, tx_ninth, tx_buf} : {2'b11, tx_buf}; // [R22]
				tx_left <= flen - 4'h1;
				tx_busy <= 1'b1;
			end else if (go_idle) begin
				tx_pin  <= 1'b1;                 // line rests high [R6]
				tx_busy <= 1'b0;
			end else if (tx_tick) begin
				tx_pin  <= tx_sh[0];
				tx_sh   <= {1'b1, tx_sh[9:1]};
				tx_left <= tx_left - 4'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	// pin synchroniser, no reader of stage one but stage two
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else if (clk_en) begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
		end
	end

	// start detect, three-sample vote mid bit, data assembly
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_st   <= RX_IDLE;
			rx_ph   <= 4'h0;
			rx_bit  <= 4'h0;
			rx_data <= 9'h000;
			smp_a   <= 1'b1;
			smp_b   <= 1'b1;
			noise   <= 1'b0;
		end else if (smp_tick) begin
			case (rx_st)
				RX_IDLE: begin
					if (!rx_s2) begin
						rx_st  <= RX_BUSY;      // falling edge seen
						rx_ph  <= 4'h1;
						rx_bit <= 4'h0;
						noise  <= 1'b0;
					end
				end
				RX_BUSY: begin
					rx_ph <= rx_ph + 4'h1;
					if (rx_ph == SMP_A) begin
						smp_a <= rx_s2;
					end
					if (rx_ph == SMP_B) begin
						smp_b <= rx_s2;
					end
					if (rx_ph == SMP_C) begin
						if ((rx_bit == 4'h0) && maj) begin
							rx_st <= RX_IDLE;   // false start rejected [R17]
						end else begin
							noise  <= noise | dis;
							rx_bit <= rx_bit + 4'h1;
							if ((rx_bit != 4'h0) && (rx_bit < flen - 4'h1)) begin
								rx_data[rx_bit - 4'h1] <= maj;
							end
							if (rx_bit == flen - 4'h1) begin
								rx_st <= RX_IDLE;
							end
						end
					end
				end
				default: rx_st <= RX_IDLE;
			endcase
		end
	end

	// high-line counter for idle detection and wakeup
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			idle_cnt   <= 8'h00;
			idle_armed <= 1'b0;
		end else if (smp_tick) begin
			if ((rx_st != RX_IDLE) || !rx_s2) begin
				idle_cnt <= 8'h00;
			end else if (idle_cnt != ithr) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
			if (rx_done) begin
				idle_armed <= 1'b1;
			end else if (idle_hit) begin
				idle_armed <= 1'b0;
			end
		end
	end

	// receive flags; any new event wins over the clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_buf_full   <= 1'b0;
			ovr    <= 1'b0;
			nf     <= 1'b0;
			fe     <= 1'b0;
			idle_f <= 1'b0;
			rx_arm <= 1'b0;
		end else begin
			if (st_rd & (rx_buf_full | idle_f | ovr | nf | fe)) begin
				rx_arm <= 1'b1;
			end else if (dt_rd) begin
				rx_arm <= 1'b0;
			end
			if (accept & ~rx_buf_full) begin
				rx_buf_full <= 1'b1;                    // [R13]
				nf   <= noise | dis;             // [R17]
				fe   <= ~maj;                    // bad stop [R18]
			end else if (rx_clr) begin
				rx_buf_full <= 1'b0;
				nf   <= 1'b0;
				fe   <= 1'b0;
			end
			if (accept & rx_buf_full) begin
				ovr <= 1'b1;                     // framing left alone [R19] [R25]
			end else if (rx_clr) begin
				ovr <= 1'b0;
			end
			if (idle_hit & idle_armed & re) begin
				idle_f <= 1'b1;                  // [R20]
			end else if (rx_clr) begin
				idle_f <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_status_arm;
		st_rd && tx_buf_empty;
	endsequence
	sequence s_data_write;
		dt_wr && !load_dat;
	endsequence
	sequence s_quiet;
		!dt_wr && !load_dat;
	endsequence

	a_start_bit_low: assert property (@(posedge clock) disable iff (rst) // [R4]
		load_dat |=> !tx_pin) else $error("start bit not low");
	a_tx_buf_empty_on_load: assert property (@(posedge clock) disable iff (rst) // [R5]
		load_dat |=> tx_buf_empty && tx_busy) else $error("empty flag not set on load");
	a_idle_pin_high: assert property (@(posedge clock) disable iff (rst) // [R6]
		!tx_busy |-> tx_pin) else $error("idle line not high");
	a_break_low: assert property (@(posedge clock) disable iff (rst) // [R7]
		load_brk |=> !tx_pin && brk_end) else $error("break bit not low");
	a_break_tail: assert property (@(posedge clock) disable iff (rst) // [R8]
		load_one |=> tx_pin && !brk_end) else $error("no one after break");
	a_tx_buf_empty_clear: assert property (@(posedge clock) disable iff (rst) // [R23]
		s_status_arm ##1 s_data_write |=> !tx_buf_empty)
		else $error("empty flag not cleared");
	a_tx_buf_empty_clear_gap: assert property (@(posedge clock) disable iff (rst) // [R23]
		s_status_arm ##1 s_quiet ##1 s_data_write |=> !tx_buf_empty)
		else $error("empty flag not cleared after gap");
	a_fe_with_rx_buf_full: assert property (@(posedge clock) disable iff (rst) // [R18]
		$rose(fe) |-> $rose(rx_buf_full)) else $error("framing flag without full");
	a_nf_with_rx_buf_full: assert property (@(posedge clock) disable iff (rst) // [R17]
		$rose(nf) |-> $rose(rx_buf_full)) else $error("noise flag without full");
	a_or_over_fe: assert property (@(posedge clock) disable iff (rst) // [R25]
		(accept && rx_buf_full && !rx_clr) |=> ovr && (fe == $past(fe)))
		else $error("overrun touched framing flag");
	a_rx_clear: assert property (@(posedge clock) disable iff (rst) // [R24]
		(rx_clr && !accept && !idle_hit) |=> !rx_buf_full && !ovr && !fe && !nf && !idle_f)
		else $error("receive flags not cleared");

endmodule // asp_core

// *** verif/asp_remote.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// remote serial node: drives the port's receive wire, decodes its transmit wire
// ------------------------------------------------------------
module asp_remote (
	input  wire logic clock,  // shared bench clock
	input  wire logic line,   // transmit wire from the port, pulled up
	output logic      rx_out  // wire into the port
);
	logic [7:0] got;          // last decoded byte
	int         got_cnt;      // bytes decoded so far
	initial rx_out = 1'b1;    // mark level while silent
	// one frame, lsb first; the stop level is chosen by the caller
	// nine picks an 11-bit frame; glitch flips one mid sample of that bit
	task automatic send(input logic [8:0] d, input logic stop, input logic nine,
		input int glitch);
		logic [10:0] f;
		f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			@(posedge clock);
			rx_out <= f[i];
			if (i == glitch) begin
				repeat (8) @(posedge clock);
				rx_out <= ~f[i];
				@(posedge clock);
				rx_out <= f[i];
				repeat (6) @(posedge clock);
			end else begin
				repeat (15) @(posedge clock);
			end
		end
		@(posedge clock);
		rx_out <= 1'b1;
	endtask
	// decoder: start edge, then mid-bit samples 16 clocks apart
	initial begin
		got_cnt = 0;
		forever begin
			@(negedge line);
			repeat (8) @(posedge clock);
			for (int i = 0; i < 9; i++) begin
				repeat (16) @(posedge clock);
				if (i < 8) got[i] = line;
			end
			got_cnt++;
		end
	end
endmodule // asp_remote

// *** verif/asp_core_test.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module asp_core_test;
	import asp_pkg::*;
	// ------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------
	typedef struct {logic [7:0] d; logic stop; int g; logic [7:0] flags;} asp_row_t;
	logic              clock = 0, rst = 1, wr_stb = 0, rd_stb = 0; // bench drive
	logic [ADDR_W-1:0] addr = '0;                                   // register index
	logic [7:0]        wr_data = 8'h00, rd_data, q;                 // bus data
	logic              tx_pin, tx_oe_n, irq, rx_wire, line;         // pins
	int                n_mismatch = 0, n_tests = 0, cyc = 0;        // counters
	asp_row_t rows [5] = '{'{8'h55, 1'b1, -1, 8'h20}, '{8'hA3, 1'b1, -1, 8'h20},
		'{8'h00, 1'b0, -1, 8'h22}, '{8'hFF, 1'b1, -1, 8'h20},
		'{8'h3C, 1'b1, 2, 8'h24}};                               // rx cases
	assign line = tx_oe_n ? 1'b1 : tx_pin; // pull-up when released
	always #2.5 clock = ~clock;
	asp_core dut (.clock(clock), .rst(rst), .clk_en(1'b1), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rx_pin(rx_wire),
		.tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .irq(irq));
	asp_remote remote (.clock(clock), .line(line), .rx_out(rx_wire));
	// ------------------------------------------------------------
	// bus tasks, verdict and hang guard
	// ------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clock);
		wr_stb <= 1'b1; addr <= a; wr_data <= d;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge clock);
		rd_stb <= 1'b1; addr <= a;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic conclude();
		if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(A_STATUS, q); `CHK(q, {TX_BUF_EMPTY_RST, TC_RST, 6'h00})
		rd(A_CTRL2, q); `CHK(q, CTRL2_RST)
		rd(3'h5, q); `CHK(q, 8'h00)
		`CHK(tx_oe_n, 1'b1)
		wr(A_BAUD, 8'h00);
		wr(A_CTRL1, 8'h00);
		wr(A_CTRL2, 8'h04);
		// ordinary receive cases, then the clear sequence
		foreach (rows[i]) begin
			remote.send({1'b0, rows[i].d}, rows[i].stop, 1'b0, rows[i].g);
			repeat (4) @(posedge clock);
			rd(A_STATUS, q); `CHK(q & 8'h2E, rows[i].flags)
			rd(A_DATA, q); `CHK(q, rows[i].d)
			rd(A_STATUS, q); `CHK(q & 8'h2E, 8'h00)
		end
		// overrun beside a bad stop: only overrun, first byte kept
		wr(A_CTRL2, 8'h24);
		remote.send(9'h011, 1'b1, 1'b0, -1);
		remote.send(9'h022, 1'b0, 1'b0, -1);
		repeat (4) @(posedge clock);
		rd(A_STATUS, q); `CHK(q & 8'h2E, 8'h28)
		`CHK(irq, 1'b1)
		rd(A_DATA, q); `CHK(q, 8'h11)
		// nine-bit character: ninth bit lands beside the data byte
		wr(A_CTRL1, 8'h10);
		remote.send(9'h1A5, 1'b1, 1'b1, -1);
		repeat (4) @(posedge clock);
		rd(A_CTRL1, q); `CHK(q & 8'h90, 8'h90)
		rd(A_STATUS, q); `CHK(q & 8'h2E, 8'h20)
		rd(A_DATA, q); `CHK(q, 8'hA5)
		// standby with address-mark wakeup
		wr(A_CTRL1, 8'h08);
		wr(A_CTRL2, 8'h26);
		remote.send(9'h001, 1'b1, 1'b0, -1);
		repeat (4) @(posedge clock);
		rd(A_STATUS, q); `CHK(q & 8'h20, 8'h00)
		`CHK(irq, 1'b0)
		remote.send(9'h080, 1'b1, 1'b0, -1);
		repeat (4) @(posedge clock);
		rd(A_CTRL2, q); `CHK(q & 8'h02, 8'h00)
		rd(A_STATUS, q); `CHK(q & 8'h20, 8'h20)
		rd(A_DATA, q); `CHK(q, 8'h80)
		// standby with idle-line wakeup: dropped character, then a quiet line
		wr(A_CTRL1, 8'h00);
		wr(A_CTRL2, 8'h26);
		remote.send(9'h055, 1'b1, 1'b0, -1);
		repeat (200) @(posedge clock);
		rd(A_CTRL2, q); `CHK(q & 8'h02, 8'h00)
		rd(A_STATUS, q); `CHK(q & 8'h30, 8'h10)
		// transmit, with enable dropped during the character
		wr(A_CTRL2, 8'h08);
		rd(A_STATUS, q);
		wr(A_DATA, 8'hC6);
		for (int k = 0; k < 1000 && tx_pin !== 1'b0; k++) @(posedge clock);
		wr(A_CTRL2, 8'h00);
		`CHK(tx_oe_n, 1'b0)
		for (int k = 0; k < 1000 && remote.got_cnt != 1; k++) @(posedge clock);
		`CHK(remote.got, 8'hC6)
		repeat (30) @(posedge clock);
		rd(A_STATUS, q); `CHK(q & 8'hC0, 8'hC0)
		`CHK(tx_oe_n, 1'b1)
		// break: continuous zeros, then a one
		wr(A_CTRL2, 8'h09);
		for (int k = 0; k < 1000 && tx_pin !== 1'b0; k++) @(posedge clock);
		repeat (150) @(posedge clock);
		`CHK(tx_pin, 1'b0)
		wr(A_CTRL2, 8'h08);
		for (int k = 0; k < 400 && tx_pin !== 1'b1; k++) @(posedge clock);
		repeat (15) @(posedge clock);
		`CHK(tx_pin, 1'b1)
		conclude();
	end
endmodule // asp_core_test
